// ---- logic/ffmd_core.sv ----
/*
 * Freefall/motion detector: per-axis threshold compare, AND/OR
 * combination, debounce counter, source/threshold/count registers.
 * Assumes a register port fed by the serial interface slave on core_clk,
 * samples arriving on core_clk, and configuration levels held stable.
 */
`timescale 1ns/100ps
`include "ffmd_params.svh"

module ffmd_core #(
    parameter logic [17:0] TICK_CYCLES = 18'(`FFMD_TICK_CYC)
) (
    input  wire logic                    core_clk,
    input  wire logic                    nrst,
    input  wire logic                    sample_valid,
    input  wire ffmd_pkg::ffmd_sample_s  sample,
    input  wire logic [1:0]              full_scale,
    input  wire logic [2:0]              output_data_rate,
    input  wire ffmd_pkg::ffmd_osr_e     osr_mode,
    input  wire logic                    low_noise,
    input  wire ffmd_pkg::ffmd_cfg_s     motion_config,
    input  wire logic                    motion_irq_enable,
    input  wire logic                    motion_irq_route,
    input  wire ffmd_pkg::ffmd_reg_req_s reg_req,
    output logic [7:0]                   reg_rdata,
    output logic                         reg_rvalid,
    output logic                         event_active,
    output logic                         irq_pin1,
    output logic                         irq_pin2
);
    ffmd_pkg::ffmd_core_s st_r;
    ffmd_pkg::ffmd_core_s st_nxt;
    ffmd_pkg::ffmd_axis_s res_x;
    ffmd_pkg::ffmd_axis_s res_y;
    ffmd_pkg::ffmd_axis_s res_z;
    logic [6:0]           eff_thr;
    logic                 step_en;
    logic [2:0]           axis_en;
    logic [2:0]           hi_now;
    logic [2:0]           neg_now;
    logic [2:0]           hi_en;
    logic [2:0]           lo_en;
    logic                 cond;
    logic                 rd_src;
    logic                 frozen;
    logic                 clear_mode;
    logic [7:0]           cnt_base;
    logic [7:0]           cnt_new;
    logic                 ea_base;
    logic                 ea_new;
    ffmd_pkg::ffmd_src_s  src_view;

    // low-noise operation cannot reach past 4g, so the field is clipped
    assign eff_thr = (low_noise && st_r.threshold_field[`FFMD_THS_FIELD_MSB:0] > `FFMD_LN_THS_MAX)
                   ? `FFMD_LN_THS_MAX
                   : st_r.threshold_field[`FFMD_THS_FIELD_MSB:0];

    assign axis_en = {motion_config.z_axis_enable,
                      motion_config.y_axis_enable,
                      motion_config.x_axis_enable};

    assign clear_mode = st_r.threshold_field[`FFMD_THS_MODE_BIT];

    // one comparator per axis, all fed the same threshold
    ffmd_axis_cmp u_cmp_x (
        .sample     (sample.x),
        .full_scale (full_scale),
        .threshold  (eff_thr),
        .result     (res_x)
    );

    ffmd_axis_cmp u_cmp_y (
        .sample     (sample.y),
        .full_scale (full_scale),
        .threshold  (eff_thr),
        .result     (res_y)
    );

    ffmd_axis_cmp u_cmp_z (
        .sample     (sample.z),
        .full_scale (full_scale),
        .threshold  (eff_thr),
        .result     (res_z)
    );

    // debounce steps follow the data rate and oversampling mode
    ffmd_step_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_step (
        .core_clk         (core_clk),
        .nrst             (nrst),
        .sample_valid     (sample_valid),
        .output_data_rate (output_data_rate),
        .osr_mode         (osr_mode),
        .step_en          (step_en)
    );

    // live comparison on a sample, else the last sample's result holds;
    // a step between samples reuses it rather than inventing data
    always_comb
    begin
        if (sample_valid)
        begin
            hi_now  = {res_z.hi, res_y.hi, res_x.hi};
            neg_now = {res_z.neg, res_y.neg, res_x.neg};
        end
        else
        begin
            hi_now  = st_r.hi;
            neg_now = st_r.neg;
        end
    end

    // per-axis conditions and the selected combination
    always_comb
    begin
        hi_en = hi_now & axis_en;
        lo_en = ~hi_now & axis_en;
        if (motion_config.or_and_select)
            cond = |hi_en;
        else
            cond = (&(lo_en | ~axis_en)) & (|axis_en);
    end

    // read view: disabled axes always read zero, bit 6 is fixed low
    always_comb
    begin
        src_view = st_r.src;
        src_view.zero = 1'b0;
        src_view.z_axis_event    = st_r.src.z_axis_event & axis_en[2];
        src_view.z_axis_polarity = st_r.src.z_axis_polarity & axis_en[2];
        src_view.y_axis_event    = st_r.src.y_axis_event & axis_en[1];
        src_view.y_axis_polarity = st_r.src.y_axis_polarity & axis_en[1];
        src_view.x_axis_event    = st_r.src.x_axis_event & axis_en[0];
        src_view.x_axis_polarity = st_r.src.x_axis_polarity & axis_en[0];
    end

    assign rd_src = reg_req.rd && (reg_req.addr == `FFMD_ADDR_SRC);

    // a latched source read clears first; this cycle's sample and step are
    // then applied on top, so an event qualifying now survives the read
    always_comb
    begin
        if (rd_src && motion_config.event_latch_enable)
        begin
            cnt_base = '0;
            ea_base  = 1'b0;
        end
        else
        begin
            cnt_base = st_r.cnt;
            ea_base  = st_r.src.event_active;
        end
    end

    // debounce counter: up while the condition holds, saturating at the
    // programmed count; on a miss either cleared or walked down by one
    always_comb
    begin
        cnt_new = cnt_base;
        if (step_en)
        begin
            if (cond)
            begin
                if (cnt_base < st_r.dbc)
                    cnt_new = cnt_base + 8'h1;
                else
                    cnt_new = st_r.dbc;
            end
            else if (clear_mode)
            begin
                cnt_new = 8'h00;
            end
            else if (cnt_base != 8'h00)
            begin
                cnt_new = cnt_base - 8'h1;
            end
        end
    end

    // event active: latched until a source read, or in real time;
    // decrement mode keeps it up until the counter has run down to zero
    always_comb
    begin
        ea_new = ea_base;
        if (step_en)
        begin
            if (motion_config.event_latch_enable)
            begin
                ea_new = ea_base | (cond && cnt_new == st_r.dbc);
            end
            else if (cond)
            begin
                ea_new = ea_base | (cnt_new == st_r.dbc);
            end
            else if (clear_mode)
            begin
                ea_new = 1'b0;
            end
            else
            begin
                ea_new = ea_base & (cnt_new != 8'h00);
            end
        end
    end

    // next state: registers, flags, counter and read port
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.rvalid = reg_req.rd;
        frozen = motion_config.event_latch_enable & ea_base;

        // register reads sample the pre-update state as one snapshot
        if (reg_req.rd)
        begin
            unique case (reg_req.addr)
                `FFMD_ADDR_SRC: st_nxt.rdata = src_view;
                `FFMD_ADDR_THS: st_nxt.rdata = st_r.threshold_field;
                `FFMD_ADDR_CNT: st_nxt.rdata = st_r.dbc;
                default:        st_nxt.rdata = 8'h00;
            endcase
        end

        // only the two writable registers take writes; the source ignores them
        if (reg_req.wr)
        begin
            if (reg_req.addr == `FFMD_ADDR_THS)
                st_nxt.threshold_field = reg_req.wdata;
            else if (reg_req.addr == `FFMD_ADDR_CNT)
                st_nxt.dbc = reg_req.wdata;
        end

        // a latched read wipes the axis flags along with the event
        if (rd_src && motion_config.event_latch_enable)
        begin
            st_nxt.src = '0;
        end

        // axis flags follow each sample undebounced unless frozen
        if (sample_valid)
        begin
            st_nxt.hi  = hi_now;
            st_nxt.neg = neg_now;
            if (!frozen)
            begin
                st_nxt.src.z_axis_event    = hi_en[2];
                st_nxt.src.z_axis_polarity = hi_en[2] & neg_now[2];
                st_nxt.src.y_axis_event    = hi_en[1];
                st_nxt.src.y_axis_polarity = hi_en[1] & neg_now[1];
                st_nxt.src.x_axis_event    = hi_en[0];
                st_nxt.src.x_axis_polarity = hi_en[0] & neg_now[0];
            end
        end

        st_nxt.cnt = cnt_new;
        st_nxt.src.event_active = ea_new;
        st_nxt.src.zero = 1'b0;
    end

    // all state in one register bank, cleared to defaults by reset
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r        <= '0;
            st_r.src    <= `FFMD_SRC_RST;
            st_r.threshold_field    <= `FFMD_THS_RST;
            st_r.dbc    <= `FFMD_CNT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // outputs; the interrupt pin choice is a plain gate on the event flag
    assign reg_rdata    = st_r.rdata;
    assign reg_rvalid   = st_r.rvalid;
    assign event_active = st_r.src.event_active;
    assign irq_pin1     = st_r.src.event_active & motion_irq_enable & motion_irq_route;
    assign irq_pin2     = st_r.src.event_active & motion_irq_enable & ~motion_irq_route;

endmodule

// ---- logic/ffmd_params.svh ----
/*
 * Constants of the freefall/motion detector: register offsets, field
 * positions, reset values and debounce timing.
 * Assumes a 200 MHz core clock; included by bare name where needed.
 */
`ifndef FFMD_PARAMS_SVH
`define FFMD_PARAMS_SVH

`define FFMD_ADDR_SRC       8'h16
`define FFMD_ADDR_THS       8'h17
`define FFMD_ADDR_CNT       8'h18
`define FFMD_SRC_RST        8'h00
`define FFMD_THS_RST        8'h00
`define FFMD_CNT_RST        8'h00
`define FFMD_THS_MODE_BIT   7
`define FFMD_THS_FIELD_MSB  6
`define FFMD_LN_THS_MAX     7'h3F
`define FFMD_STEP_BASE_US   1250
`define FFMD_CLK_MHZ        200
`define FFMD_TICK_CYC       (`FFMD_STEP_BASE_US * `FFMD_CLK_MHZ)
`define FFMD_FLOOR_NORMAL   4'h4
`define FFMD_FLOOR_LOW_POWER_LOW_NOISE_MODE     4'h6
`define FFMD_FLOOR_HIRES    4'h1
`define FFMD_FLOOR_LP       4'h7

`endif

// ---- logic/ffmd_pkg.sv ----
/*
 * Types shared by the freefall/motion detector modules.
 * Assumes nothing of its surroundings; every user writes ffmd_pkg::name.
 */
package ffmd_pkg;

    typedef enum logic [1:0] {
        FFMD_OSR_NORMAL = 2'b00,
        FFMD_OSR_LOW_POWER_LOW_NOISE_MODE   = 2'b01,
        FFMD_OSR_HIRES  = 2'b10,
        FFMD_OSR_LP     = 2'b11
    } ffmd_osr_e;

    typedef struct packed {
        logic event_latch_enable;
        logic or_and_select;
        logic z_axis_enable;
        logic y_axis_enable;
        logic x_axis_enable;
    } ffmd_cfg_s;

    typedef struct packed {
        logic event_active;
        logic zero;
        logic z_axis_event;
        logic z_axis_polarity;
        logic y_axis_event;
        logic y_axis_polarity;
        logic x_axis_event;
        logic x_axis_polarity;
    } ffmd_src_s;

    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ffmd_reg_req_s;

    typedef struct packed {
        logic signed [11:0] x;
        logic signed [11:0] y;
        logic signed [11:0] z;
    } ffmd_sample_s;

    typedef struct packed {
        logic hi;
        logic neg;
    } ffmd_axis_s;

    typedef struct packed {
        ffmd_src_s  src;
        logic [7:0] cnt;
        logic [7:0] threshold_field;
        logic [7:0] dbc;
        logic [2:0] hi;
        logic [2:0] neg;
        logic [7:0] rdata;
        logic       rvalid;
    } ffmd_core_s;

    typedef struct packed {
        logic [17:0] base;
        logic [8:0]  step;
    } ffmd_step_s;

endpackage

// ---- logic/ffmd_axis_cmp.sv ----
/*
 * One axis of threshold comparison: magnitude, rescale to 1/16 g units,
 * compare against the effective threshold, report the sign.
 * Assumes a 12-bit two's complement sample at the selected full scale.
 */
`timescale 1ns/100ps

module ffmd_axis_cmp (
    input  wire logic signed [11:0] sample,
    input  wire logic [1:0]         full_scale,
    input  wire logic [6:0]         threshold,
    output ffmd_pkg::ffmd_axis_s    result
);
    logic [11:0] mag;
    logic [7:0]  scaled;

    // 2g keeps 1024 counts per g, 8g keeps 256; threshold counts are 1/16 g
    always_comb
    begin
        mag = sample[11] ? 12'(-sample) : 12'(sample);
        unique case (full_scale)
            2'h0:    scaled = 8'(mag >> 6);
            2'h1:    scaled = 8'(mag >> 5);
            default: scaled = 8'(mag >> 4);    // 8g and the reserved code
        endcase
        result.hi  = scaled > {1'b0, threshold};
        result.neg = sample[11];
    end

endmodule

// ---- logic/ffmd_step_gen.sv ----
/*
 * Debounce time step generator: one-cycle enable per debounce step.
 * Assumes sample_valid pulses once per output sample on core_clk.
 */
`timescale 1ns/100ps
`include "ffmd_params.svh"

module ffmd_step_gen #(
    parameter logic [17:0] TICK_CYCLES = 18'(`FFMD_TICK_CYC)
) (
    input  wire logic                core_clk,
    input  wire logic                nrst,
    input  wire logic                sample_valid,
    input  wire logic [2:0]          output_data_rate,
    input  wire ffmd_pkg::ffmd_osr_e osr_mode,
    output logic                     step_en
);
    ffmd_pkg::ffmd_step_s st_r, st_nxt;
    logic [3:0] smp_sh;
    logic [3:0] floor_sh;
    logic [3:0] step_sh;
    logic       tick;

    // sample period and mode floor, both as log2 of 1.25 ms ticks
    always_comb
    begin
        unique case (output_data_rate)
            3'h0: smp_sh = 4'h0;
            3'h1: smp_sh = 4'h1;
            3'h2: smp_sh = 4'h2;
            3'h3: smp_sh = 4'h3;
            3'h4: smp_sh = 4'h4;
            3'h5: smp_sh = 4'h6;
            3'h6: smp_sh = 4'h7;
            3'h7: smp_sh = 4'h9;
        endcase
        unique case (osr_mode)
            ffmd_pkg::FFMD_OSR_NORMAL: floor_sh = `FFMD_FLOOR_NORMAL;
            ffmd_pkg::FFMD_OSR_LOW_POWER_LOW_NOISE_MODE:   floor_sh = `FFMD_FLOOR_LOW_POWER_LOW_NOISE_MODE;
            ffmd_pkg::FFMD_OSR_HIRES:  floor_sh = `FFMD_FLOOR_HIRES;
            ffmd_pkg::FFMD_OSR_LP:     floor_sh = `FFMD_FLOOR_LP;
        endcase
        step_sh = (smp_sh > floor_sh) ? floor_sh : smp_sh;
    end

    // a sample restarts the divider so steps stay aligned to samples
    always_comb
    begin
        st_nxt = st_r;
        tick = st_r.base == TICK_CYCLES - 18'h1;
        step_en = sample_valid;
        if (sample_valid)
        begin
            st_nxt = '0;
        end
        else if (tick)
        begin
            st_nxt.base = '0;
            st_nxt.step = st_r.step + 9'h1;
            if (st_r.step == 9'((10'h1 << step_sh) - 10'h1))
            begin
                st_nxt.step = '0;
                step_en = step_sh != smp_sh;
            end
        end
        else
        begin
            st_nxt.base = st_r.base + 18'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

endmodule

// ---- tb/ffmd_core_chk.sv ----
/*
 * Port-level assertions for ffmd_core, bound into every instance.
 * Assumes configuration inputs stay steady around source register reads.
 */
`timescale 1ns/100ps

module ffmd_core_chk (
    input wire logic                    core_clk,
    input wire logic                    nrst,
    input wire logic                    sample_valid,
    input wire logic [2:0]              output_data_rate,
    input wire ffmd_pkg::ffmd_cfg_s     motion_config,
    input wire logic                    motion_irq_enable,
    input wire logic                    motion_irq_route,
    input wire ffmd_pkg::ffmd_reg_req_s reg_req,
    input wire logic [7:0]              reg_rdata,
    input wire logic                    reg_rvalid,
    input wire logic                    event_active,
    input wire logic                    irq_pin1,
    input wire logic                    irq_pin2
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // a source read and the shape of its answer one cycle on
    sequence src_read;
        reg_req.rd && reg_req.addr == 8'h16;
    endsequence
    sequence src_answer;
        reg_rvalid && reg_rdata[6] == 1'b0;
    endsequence

    // register port timing: every read answered exactly one cycle later
    rd_answer_a: assert property (reg_req.rd |=> reg_rvalid)
        else $error("read not answered one cycle later");
    rd_cause_a: assert property (reg_rvalid |-> $past(reg_req.rd))
        else $error("read answer without a request");
    bit_six_a: assert property (src_read |=> src_answer)
        else $error("source bit 6 not zero");
    snap_event_a: assert property (src_read |=> reg_rdata[7] == $past(event_active))
        else $error("source read disagrees with event output");
    z_masked_a: assert property (src_read ##0 !motion_config.z_axis_enable
        |=> reg_rdata[5:4] == 2'h0)
        else $error("disabled z flags not zero");
    x_masked_a: assert property (src_read ##0 !motion_config.x_axis_enable
        |=> reg_rdata[1:0] == 2'h0)
        else $error("disabled x flags not zero");

    // interrupt gating is a pure level function of the event and routing
    irq_first_a: assert property (irq_pin1 == (event_active && motion_irq_enable
        && motion_irq_route))
        else $error("first interrupt pin wrong");
    irq_second_a: assert property (irq_pin2 == (event_active && motion_irq_enable
        && !motion_irq_route))
        else $error("second interrupt pin wrong");

    // a latched event may only fall because the source was read
    latch_hold_a: assert property ($fell(event_active) && motion_config.event_latch_enable
        |-> $past(reg_req.rd && reg_req.addr == 8'h16))
        else $error("latched event dropped without a read");
    // at the fastest rate only a sample can raise the event
    rise_cause_a: assert property ($rose(event_active) && output_data_rate == 3'h0
        |-> $past(sample_valid))
        else $error("event rose without a sample");
endmodule

bind ffmd_core ffmd_core_chk chk_u (
    .core_clk(core_clk), .nrst(nrst), .sample_valid(sample_valid),
    .output_data_rate(output_data_rate), .motion_config(motion_config),
    .motion_irq_enable(motion_irq_enable), .motion_irq_route(motion_irq_route),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .event_active(event_active), .irq_pin1(irq_pin1), .irq_pin2(irq_pin2)
);

// ---- tb/ffmd_host.sv ----
/*
 * Host model: single-byte register reads and writes on the register port.
 * Assumes the detector registers a read's answer on the taking edge itself.
 */
`timescale 1ns/100ps

module ffmd_host (
    input  wire logic               core_clk,
    output ffmd_pkg::ffmd_reg_req_s reg_req,
    input  wire logic [7:0]         reg_rdata,
    input  wire logic               reg_rvalid
);
    initial reg_req = '0;

    // write held over one taking edge; address scrambled after so stale values never match
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    // read; a missing answer comes back unknown so the caller's compare fails
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(posedge core_clk);
        #1;
        reg_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
        data = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
endmodule

// ---- tb/freefall_motion_detector_bench.sv ----
/*
 * Self-checking bench for ffmd_core: registers, debounce modes, latching,
 * freefall boundary and a seeded random sweep of axis compares.
 * Assumes ffmd_host drives the register port and ffmd_core_chk is bound.
 */
`timescale 1ns/100ps

module freefall_motion_detector_bench;
    logic                    core_clk, nrst, sample_valid, low_noise;
    logic                    irq_en, irq_route, reg_rvalid, evt, irq1, irq2;
    logic [1:0]              full_scale, ex, ey, ez;
    logic [2:0]              data_rate;
    logic [7:0]              reg_rdata, got, thr_reg;
    logic [11:0]             sx, sy, sz;
    ffmd_pkg::ffmd_osr_e     osr;
    ffmd_pkg::ffmd_cfg_s     cfg;
    ffmd_pkg::ffmd_sample_s  sample;
    ffmd_pkg::ffmd_reg_req_s reg_req;
    int                      n_errors, tests_run, seed;

    ffmd_core #(.TICK_CYCLES(18'h00008)) dut_u (
        .core_clk(core_clk), .nrst(nrst), .sample_valid(sample_valid), .sample(sample),
        .full_scale(full_scale), .output_data_rate(data_rate), .osr_mode(osr),
        .low_noise(low_noise), .motion_config(cfg), .motion_irq_enable(irq_en),
        .motion_irq_route(irq_route), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .event_active(evt), .irq_pin1(irq1), .irq_pin2(irq2)
    );
    ffmd_host host_u (
        .core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // whole run is under 10 us; a hang past this is a failure
    initial
    begin
        #50000;
        n_errors++;
        close_out();
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] expd);
        tests_run++;
        if (seen !== expd)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, expd);
        end
    endtask

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // expected {event, polarity} of one axis; magnitude rescaled to 1/16 g counts
    function automatic logic [1:0] axis_exp(input logic [11:0] v, input logic en);
        logic [11:0] mag;
        logic [6:0]  lim;
        mag = v[11] ? 12'(-v) : v;
        lim = (low_noise && thr_reg[6:0] > 7'h3F) ? 7'h3F : thr_reg[6:0];
        mag = mag >> (full_scale == 2'h0 ? 6 : (full_scale == 2'h1 ? 5 : 4));
        axis_exp = {en && mag > {5'h00, lim}, en && mag > {5'h00, lim} && v[11]};
    endfunction

    task automatic rchk(input logic [7:0] addr, input logic [7:0] expd);
        host_u.rd(addr, got);
        check(got, expd);
    endtask

    // one sample pulse, then two cycles for the flags to settle
    task automatic send(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(posedge core_clk);
        #1;
        sample = '{x: x, y: y, z: z};
        sample_valid = 1'b1;
        @(posedge core_clk);
        #1;
        sample = '{x: ~x, y: ~y, z: ~z};
        sample_valid = 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    // one hit, then only the steps between samples may finish a count of 2;
    // cyc is the step length in core cycles (1.25 ms tick = 8 cycles here)
    task automatic step_case(input logic [2:0] r, input ffmd_pkg::ffmd_osr_e m, input int cyc);
        data_rate = r;
        osr = m;
        setup(5'h0F, 8'h90, 8'h02);
        send(12'h000, 12'h000, 12'hC18);
        repeat (cyc - 3) @(posedge core_clk);
        #1;
        check({7'h00, evt}, 8'h00);
        @(posedge core_clk);
        #1;
        check({7'h00, evt}, 8'h01);
    endtask

    // mid-run reset keeps debounce history out of the next scenario
    task automatic setup(input logic [4:0] c, input logic [7:0] t, input logic [7:0] n);
        nrst = 1'b0;
        cfg = c;
        thr_reg = t;
        repeat (2) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        host_u.wr(8'h17, t);
        host_u.wr(8'h18, n);
    endtask

    // z hit pattern read from bit n-1 down to bit 0, event expected after each sample
    task automatic run_seq(input int n, input logic [15:0] hits, input logic [15:0] evts);
        for (int i = n - 1; i >= 0; i--)
        begin
            send(12'h000, 12'h000, hits[i] ? 12'hC18 : 12'h000);
            check({7'h00, evt}, {7'h00, evts[i]});
        end
    endtask

    initial
    begin
        seed = 44;
        n_errors = 0;
        tests_run = 0;
        nrst = 1'b0;
        sample_valid = 1'b0;
        sample = '0;
        full_scale = 2'h2;
        data_rate = 3'h0;
        osr = ffmd_pkg::FFMD_OSR_NORMAL;
        low_noise = 1'b0;
        cfg = '0;
        irq_en = 1'b0;
        irq_route = 1'b0;
        thr_reg = 8'h00;
        repeat (2) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        rchk(8'h16, 8'h00);
        rchk(8'h17, 8'h00);
        rchk(8'h18, 8'h00);
        host_u.wr(8'h16, 8'hFF);
        rchk(8'h16, 8'h00);
        rchk(8'h20, 8'h00);
        host_u.wr(8'h17, 8'hA5);
        rchk(8'h17, 8'hA5);
        host_u.wr(8'h18, 8'hFF);
        rchk(8'h18, 8'hFF);
        $display("register test done");
        // clear mode, count 3: a miss restarts the count and drops the event at once
        setup(5'h0F, 8'h90, 8'h03);
        run_seq(8, 16'h00F7, 16'h0031);
        rchk(8'h16, 8'hB0);
        rchk(8'h16, 8'hB0);
        // decrement mode, count 3: each miss steps the count down by one
        setup(5'h0F, 8'h10, 8'h03);
        run_seq(13, 16'h1D1B, 16'h07C1);
        $display("debounce test done");
        // latched motion on x only, z high but disabled
        irq_en = 1'b1;
        irq_route = 1'b1;
        setup(5'h19, 8'h90, 8'h01);
        send(12'h3E8, 12'h000, 12'hC18);
        check({6'h00, irq1, irq2}, 8'h02);
        send(12'hC18, 12'h000, 12'h000);
        rchk(8'h16, 8'h82);
        check({7'h00, evt}, 8'h00);
        rchk(8'h16, 8'h00);
        $display("latch test done");
        // freefall at the boundary: z of 17 counts is high, 16 counts is low
        setup(5'h07, 8'h90, 8'h01);
        send(12'h064, 12'hF38, 12'h110);
        check({7'h00, evt}, 8'h00);
        send(12'h064, 12'hF38, 12'h10F);
        check({7'h00, evt}, 8'h01);
        rchk(8'h16, 8'h80);
        $display("freefall test done");
        // 200 Hz high-res steps every 2.5 ms, 12.5 Hz normal floors at 20 ms
        step_case(3'h2, ffmd_pkg::FFMD_OSR_HIRES, 16);
        step_case(3'h5, ffmd_pkg::FFMD_OSR_NORMAL, 128);
        data_rate = 3'h0;
        osr = ffmd_pkg::FFMD_OSR_NORMAL;
        $display("step test done");
        // random motion sweep; count 1 in clear mode so the event mirrors each sample
        setup(5'h0F, 8'h80, 8'h01);
        for (int i = 0; i < 150; i++)
        begin
            cfg = {2'b01, 3'($random(seed))};
            full_scale = 2'({$random(seed)} % 3);
            low_noise = 1'($random(seed));
            irq_en = 1'($random(seed));
            irq_route = 1'($random(seed));
            osr = ffmd_pkg::ffmd_osr_e'(2'($random(seed)));
            thr_reg = {1'b1, 7'({$random(seed)} % 70)};
            sx = 12'($random(seed) % 2048);
            sy = 12'($random(seed) % 2048);
            sz = 12'($random(seed) % 2048);
            host_u.wr(8'h17, thr_reg);
            send(sx, sy, sz);
            ex = axis_exp(sx, cfg.x_axis_enable);
            ey = axis_exp(sy, cfg.y_axis_enable);
            ez = axis_exp(sz, cfg.z_axis_enable);
            rchk(8'h16, {ex[1] | ey[1] | ez[1], 1'b0, ez, ey, ex});
            check({6'h00, irq1, irq2}, {6'h00, (ex[1] | ey[1] | ez[1]) & irq_en & irq_route,
                (ex[1] | ey[1] | ez[1]) & irq_en & ~irq_route});
        end
        $display("random test done");
        close_out();
    end
endmodule
